// File: sss_map.svh
// Purpose: offsets, field limits, reset values and timing for the stop selector
// Assumes: byte addresses on a 32-bit AHB-Lite register bus
// Notes:   included by the design module only
`ifndef SSS_MAP_SVH
`define SSS_MAP_SVH

`define SSS_OFF_PROHIBIT   8'h00
`define SSS_OFF_SERVO_OFF  8'h04
`define SSS_OFF_MAINS_OFF  8'h08
`define SSS_OFF_UV_ACTION  8'h0C
`define SSS_OFF_HOLD_TIME  8'h10
`define SSS_OFF_TORQUE     8'h14
`define SSS_OFF_APPLY      8'h18
`define SSS_OFF_STATUS     8'h1C
`define SSS_OFF_IRQ_STAT   8'h20
`define SSS_OFF_IRQ_CLR    8'h24
`define SSS_OFF_IRQ_EN     8'h28

`define SSS_PROHIBIT_MAX   2'h2
`define SSS_STOP_SEL_MAX   4'h9
`define SSS_STOP_EMG_MIN   4'h8
`define SSS_HOLD_MIN       11'h046
`define SSS_HOLD_MAX       11'h7D0
`define SSS_TORQUE_MAX     10'h1F4

`define SSS_RST_PROHIBIT   2'h0
`define SSS_RST_SERVO_OFF  4'h0
`define SSS_RST_MAINS_OFF  4'h0
`define SSS_RST_UV_ACTION  1'h1
`define SSS_RST_HOLD_TIME  11'h046
`define SSS_RST_TORQUE     10'h000

`define SSS_CLK_NS         10
`define SSS_MS_NS          1000000

`endif

// File: sss_motor_model.sv
// Purpose: shaft and power stage model that reports standstill
// Assumes: shaft coasts down once both torque paths are off
// Notes:   slow selects a long coast-down time
`timescale 1ns/1ps
`default_nettype none
module sss_motor_model
   import sss_pkg::*;
(
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire sss_drive_t drive,
   input  wire logic       slow,
   output logic            motor_stopped
);
   logic [7:0] coast_r;

   // any live torque path keeps the shaft turning, so the count restarts
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         coast_r <= 8'h00;
      end else if (drive.torque_fwd_en || drive.torque_rev_en) begin
         coast_r <= 8'h00;
      end else if (coast_r != 8'hFF) begin
         coast_r <= coast_r + 8'h01;
      end
   end

   assign motor_stopped = coast_r >= (slow ? 8'h28 : 8'h08);
endmodule : sss_motor_model
`default_nettype wire

// File: sss_pkg.sv
// Purpose: shared types of the stop selector
// Assumes: constants come from sss_map.svh
// Notes:   none
`default_nettype none
package sss_pkg;
   typedef enum logic [1:0] {SSS_RUN, SSS_DECEL, SSS_STOPPED} sss_state_t;

   typedef struct packed {
      logic decel_emg;
      logic decel_free;
      logic after_free;
      logic hold_err;
   } sss_stop_act_t;

   typedef struct packed {
      logic torque_fwd_en;
      logic torque_rev_en;
      logic dyn_brake;
      logic free_run;
      logic emg_stop;
      logic servo_free;
      logic err_cnt_clear;
      logic err_cnt_hold;
   } sss_drive_t;
endpackage : sss_pkg
`default_nettype wire

// File: sss_stop_selector.sv
// Purpose: stop-sequence selector for prohibit, servo-off and mains loss
// Assumes: hclk 100 MHz, condition pins asynchronous to hclk
// Notes:   AHB-Lite slave, zero wait states, always OKAY
// Behaviour
// (RL1) prohibit with prohibit select 0 removes torque that way and applies the dynamic brake.
// (RL2) prohibit with prohibit select 1 removes torque that way and lets the motor free-run.
// (RL3) prohibit with prohibit select 2 removes torque that way and makes an emergency stop.
// (RL4) prohibit select takes 0 to 2, resets to 0 and acts only after a power cycle.
// (RL5) servo-off select 0 to 7: bit0 free-run in decel, bit1 servo free after stop, bit2 hold counter.
// (RL6) servo-off select 8 and 9 emergency-stop and clear the counter, then brake (8) or free (9).
// (RL7) mains loss uses its own select with the same ten codes, reset value 0.
// (RL8) a one-bit select, reset 1, picks undervoltage trip or plain servo off on a mains alarm.
// (RL9) the mains alarm rises only after the fault lasts the hold time, 70 to 2000 ms, default 70.
// (RL10) during an emergency stop the torque is limited to the 0 to 500 percent setting.
// (RL11) out-of-range select values are refused and the old value stays.
`timescale 1ns/1ps
`default_nettype none
`include "sss_map.svh"

module sss_stop_selector
   import sss_pkg::*;
#(
   parameter int MS_CYCLES = `SSS_MS_NS / `SSS_CLK_NS
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        prohibit_fwd,
   input  wire logic        prohibit_rev,
   input  wire logic        servo_on,
   input  wire logic        mains_ok,
   input  wire logic        motor_stopped,
   output sss_drive_t       drive,
   output logic [9:0]       torque_limit_pct,
   output logic             undervoltage_trip,
   output logic             irq
);

   function automatic sss_stop_act_t stop_decode(input logic [3:0] sel);
      sss_stop_act_t a;
      a = '0;
      if (sel >= `SSS_STOP_EMG_MIN) begin
         a.decel_emg  = 1'b1;                 // RL6
         a.after_free = sel[0];               // RL6
      end else begin
         a.decel_free = sel[0];               // RL5
         a.after_free = sel[1];               // RL5
         a.hold_err   = sel[2];               // RL5
      end
      return a;
   endfunction : stop_decode

   // ---------------- pin synchronisers
   logic [4:0] pin_meta_r;
   logic [4:0] pin_sync_r;
   logic [4:0] pin_raw;
   assign pin_raw = {motor_stopped, mains_ok, servo_on, prohibit_rev, prohibit_fwd};

   genvar gi;
   generate
      for (gi = 0; gi < 5; gi++) begin : g_sync
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               pin_meta_r[gi] <= 1'b0;
               pin_sync_r[gi] <= 1'b0;
            end else begin
               pin_meta_r[gi] <= pin_raw[gi];
               pin_sync_r[gi] <= pin_meta_r[gi];
            end
         end
      end
   endgenerate

   logic pro_fwd_s;
   logic pro_rev_s;
   logic servo_on_s;
   logic mains_ok_s;
   logic stopped_s;
   assign {stopped_s, mains_ok_s, servo_on_s, pro_rev_s, pro_fwd_s} = pin_sync_r;

   // ---------------- bus address phase
   logic       ap_wr_r;
   logic       ap_rd_r;
   logic [7:0] ap_addr_r;
   logic       acc;
   assign acc       = hsel & htrans[1] & hready;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_wr_r   <= 1'b0;
         ap_rd_r   <= 1'b0;
         ap_addr_r <= 8'h00;
      end else begin
         ap_wr_r   <= acc & hwrite;
         ap_rd_r   <= acc & ~hwrite;
         ap_addr_r <= haddr[7:0];
      end
   end

   logic wr_pro;
   logic wr_soff;
   logic wr_moff;
   logic wr_uv;
   logic wr_hold;
   logic wr_torque;
   logic wr_apply;
   logic wr_iclr;
   logic wr_ien;
   assign wr_pro    = ap_wr_r && ap_addr_r == `SSS_OFF_PROHIBIT;
   assign wr_soff   = ap_wr_r && ap_addr_r == `SSS_OFF_SERVO_OFF;
   assign wr_moff   = ap_wr_r && ap_addr_r == `SSS_OFF_MAINS_OFF;
   assign wr_uv     = ap_wr_r && ap_addr_r == `SSS_OFF_UV_ACTION;
   assign wr_hold   = ap_wr_r && ap_addr_r == `SSS_OFF_HOLD_TIME;
   assign wr_torque = ap_wr_r && ap_addr_r == `SSS_OFF_TORQUE;
   assign wr_apply  = ap_wr_r && ap_addr_r == `SSS_OFF_APPLY && hwdata[0];
   assign wr_iclr   = ap_wr_r && ap_addr_r == `SSS_OFF_IRQ_CLR;
   assign wr_ien    = ap_wr_r && ap_addr_r == `SSS_OFF_IRQ_EN;

   // ---------------- settings
   logic [1:0]  pro_pend_r;
   logic [1:0]  pro_act_r;
   logic [3:0]  soff_sel_r;
   logic [3:0]  moff_sel_r;
   logic        uv_sel_r;
   logic [10:0] hold_pend_r;
   logic [10:0] hold_act_r;
   logic [9:0]  torque_r;

   // refused values leave the register untouched, so a bad write is silent
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pro_pend_r  <= `SSS_RST_PROHIBIT;
         soff_sel_r  <= `SSS_RST_SERVO_OFF;
         moff_sel_r  <= `SSS_RST_MAINS_OFF;
         uv_sel_r    <= `SSS_RST_UV_ACTION;
         hold_pend_r <= `SSS_RST_HOLD_TIME;
         torque_r    <= `SSS_RST_TORQUE;
      end else begin
         if (wr_pro && hwdata <= 32'(`SSS_PROHIBIT_MAX))                         // RL11
            pro_pend_r <= hwdata[1:0];                                           // RL4
         if (wr_soff && hwdata <= 32'(`SSS_STOP_SEL_MAX))                        // RL11
            soff_sel_r <= hwdata[3:0];
         if (wr_moff && hwdata <= 32'(`SSS_STOP_SEL_MAX))                        // RL11
            moff_sel_r <= hwdata[3:0];                                           // RL7
         if (wr_uv && hwdata[31:1] == 31'h0)                                     // RL11
            uv_sel_r <= hwdata[0];                                               // RL8
         if (wr_hold && hwdata >= 32'(`SSS_HOLD_MIN) && hwdata <= 32'(`SSS_HOLD_MAX))
            hold_pend_r <= hwdata[10:0];                                         // RL9
         if (wr_torque && hwdata <= 32'(`SSS_TORQUE_MAX))                        // RL11
            torque_r <= hwdata[9:0];                                             // RL10
      end
   end

   // the apply write stands for the drive power cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pro_act_r  <= `SSS_RST_PROHIBIT;
         hold_act_r <= `SSS_RST_HOLD_TIME;
      end else if (wr_apply) begin
         pro_act_r  <= pro_pend_r;                                               // RL4
         hold_act_r <= hold_pend_r;                                              // RL9
      end
   end

   // ---------------- mains fault timing
   logic [16:0] ms_cnt_r;
   logic [10:0] ms_held_r;
   logic        mains_alarm;
   logic        mains_alarm_r;
   logic        uv_trip_r;
   assign mains_alarm = !mains_ok_s && ms_held_r >= hold_act_r;                  // RL9

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ms_cnt_r  <= 17'h00000;
         ms_held_r <= 11'h000;
      end else if (mains_ok_s) begin
         ms_cnt_r  <= 17'h00000;
         ms_held_r <= 11'h000;
      end else if (ms_cnt_r == 17'(MS_CYCLES - 1)) begin
         ms_cnt_r  <= 17'h00000;
         if (ms_held_r != `SSS_HOLD_MAX)
            ms_held_r <= ms_held_r + 11'h001;                                    // RL9
      end else begin
         ms_cnt_r <= ms_cnt_r + 17'h00001;
      end
   end

   // a trip is an alarm: it stays until reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mains_alarm_r <= 1'b0;
         uv_trip_r     <= 1'b0;
      end else begin
         mains_alarm_r <= mains_alarm;
         if (mains_alarm && !mains_alarm_r && uv_sel_r)
            uv_trip_r <= 1'b1;                                                   // RL8
      end
   end
   assign undervoltage_trip = uv_trip_r;

   // ---------------- stop sequence
   sss_state_t state_r;
   sss_state_t state_nxt;
   logic [3:0] cur_sel_r;
   logic       stop_req;
   logic       mains_cause;
   logic [1:0] fill_r;  // no stop until both sync stages hold real pin samples, else reset looks like servo off
   assign mains_cause = mains_alarm | uv_trip_r;
   assign stop_req    = fill_r[1] & (!servo_on_s | mains_cause);

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         SSS_RUN:     if (stop_req) state_nxt = SSS_DECEL;
         SSS_DECEL:   if (stopped_s) state_nxt = SSS_STOPPED;
         SSS_STOPPED: if (!stop_req) state_nxt = SSS_RUN;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r   <= SSS_RUN;
         cur_sel_r <= `SSS_RST_SERVO_OFF;
         fill_r    <= 2'h0;
      end else begin
         state_r <= state_nxt;
         fill_r  <= {fill_r[0], 1'b1};
         if (state_r == SSS_RUN && stop_req)
            cur_sel_r <= mains_cause ? moff_sel_r : soff_sel_r;                  // RL7
      end
   end

   sss_stop_act_t act;
   sss_drive_t    drive_nxt;
   assign act = stop_decode(cur_sel_r);

   always_comb begin
      drive_nxt = '0;
      unique case (state_r)
         SSS_RUN: begin
            drive_nxt.torque_fwd_en = servo_on_s && !pro_fwd_s;
            drive_nxt.torque_rev_en = servo_on_s && !pro_rev_s;
            if (pro_fwd_s || pro_rev_s) begin
               drive_nxt.dyn_brake = pro_act_r == 2'h0;                          // RL1
               drive_nxt.free_run  = pro_act_r == 2'h1;                          // RL2
               drive_nxt.emg_stop  = pro_act_r == 2'h2;                          // RL3
            end
         end
         SSS_DECEL: begin
            drive_nxt.emg_stop      = act.decel_emg;                             // RL6
            drive_nxt.free_run      = !act.decel_emg && act.decel_free;          // RL5
            drive_nxt.dyn_brake     = !act.decel_emg && !act.decel_free;         // RL5
            drive_nxt.err_cnt_hold  = act.hold_err;                              // RL5
            drive_nxt.err_cnt_clear = !act.hold_err;                             // RL6
         end
         SSS_STOPPED: begin
            drive_nxt.servo_free    = act.after_free;                            // RL5
            drive_nxt.dyn_brake     = !act.after_free;                           // RL6
            drive_nxt.err_cnt_hold  = act.hold_err;
            drive_nxt.err_cnt_clear = !act.hold_err;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         drive            <= '0;
         torque_limit_pct <= `SSS_TORQUE_MAX;
      end else begin
         drive            <= drive_nxt;
         torque_limit_pct <= drive_nxt.emg_stop ? torque_r : `SSS_TORQUE_MAX;   // RL10
      end
   end

   // ---------------- interrupts
   logic [3:0] irq_stat_r;
   logic [3:0] irq_en_r;
   logic [3:0] irq_ev;
   logic       pro_any_r;
   assign irq_ev = {mains_alarm && !mains_alarm_r,
                    state_r == SSS_DECEL && state_nxt == SSS_STOPPED,
                    state_r == SSS_RUN && state_nxt == SSS_DECEL,
                    (pro_fwd_s | pro_rev_s) && !pro_any_r};

   // a new event beats a clear in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_stat_r <= 4'h0;
         irq_en_r   <= 4'h0;
         pro_any_r  <= 1'b0;
      end else begin
         pro_any_r  <= pro_fwd_s | pro_rev_s;
         irq_stat_r <= (irq_stat_r & ~(wr_iclr ? hwdata[3:0] : 4'h0)) | irq_ev;
         if (wr_ien)
            irq_en_r <= hwdata[3:0];
      end
   end
   assign irq = |(irq_stat_r & irq_en_r);

   // ---------------- read path, sampled in the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (acc && !hwrite) begin
         unique case (haddr[7:0])
            `SSS_OFF_PROHIBIT:  hrdata <= {26'h0, pro_act_r, 2'h0, pro_pend_r};
            `SSS_OFF_SERVO_OFF: hrdata <= {28'h0, soff_sel_r};
            `SSS_OFF_MAINS_OFF: hrdata <= {28'h0, moff_sel_r};
            `SSS_OFF_UV_ACTION: hrdata <= {31'h0, uv_sel_r};
            `SSS_OFF_HOLD_TIME: hrdata <= {5'h0, hold_act_r, 5'h0, hold_pend_r};
            `SSS_OFF_TORQUE:    hrdata <= {22'h0, torque_r};
            `SSS_OFF_STATUS:    hrdata <= {16'h0, drive, 1'b0, state_r,
                                           mains_alarm, uv_trip_r, pin_sync_r[2:0]};
            `SSS_OFF_IRQ_STAT:  hrdata <= {28'h0, irq_stat_r};
            `SSS_OFF_IRQ_EN:    hrdata <= {28'h0, irq_en_r};
            default:            hrdata <= 32'h00000000;
         endcase
      end
   end

endmodule : sss_stop_selector
`default_nettype wire

// File: sss_stop_selector_monitor.sv
// Purpose: concurrent checks on the stop selector ports
// Assumes: one clock domain, reset active low
// Notes:   hold time bound uses the shortest legal setting
`timescale 1ns/1ps
`default_nettype none
module sss_stop_selector_monitor
   import sss_pkg::*;
#(
   parameter int MS_CYCLES = 100000
) (
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       prohibit_fwd,
   input wire logic       prohibit_rev,
   input wire logic       servo_on,
   input wire logic       mains_ok,
   input wire sss_drive_t drive,
   input wire logic [9:0] torque_limit_pct,
   input wire logic       undervoltage_trip
);
   logic [31:0] low_cnt_r;

   // raw pin count, so it leads the synced alarm by the synchroniser delay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_cnt_r <= 32'h0;
      end else if (mains_ok) begin
         low_cnt_r <= 32'h0;
      end else begin
         low_cnt_r <= low_cnt_r + 32'h1;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   torque_cap_a: assert property (
      (!drive.emg_stop)[*3] |-> torque_limit_pct == 10'h1F4) else $error("torque limit off");
   stop_act_a: assert property (
      $onehot0({drive.dyn_brake, drive.free_run, drive.emg_stop, drive.servo_free})) else $error("stop mix");
   err_mode_a: assert property (
      !(drive.err_cnt_clear && drive.err_cnt_hold)) else $error("counter clear and hold");
   uv_sticky_a: assert property (
      undervoltage_trip |=> undervoltage_trip) else $error("trip dropped");
   hold_time_a: assert property (
      $rose(undervoltage_trip) |-> low_cnt_r >= 32'(70 * MS_CYCLES)) else $error("alarm too early");
   fwd_block_a: assert property (
      prohibit_fwd[*4] |=> !drive.torque_fwd_en) else $error("fwd torque on");
   rev_block_a: assert property (
      prohibit_rev[*4] |=> !drive.torque_rev_en) else $error("rev torque on");
   off_torque_a: assert property (
      (!servo_on)[*5] |=> !drive.torque_fwd_en && !drive.torque_rev_en) else $error("torque after servo off");
endmodule : sss_stop_selector_monitor

bind sss_stop_selector sss_stop_selector_monitor #(.MS_CYCLES(MS_CYCLES)) u_monitor (
   .hclk              (hclk),
   .hresetn           (hresetn),
   .prohibit_fwd      (prohibit_fwd),
   .prohibit_rev      (prohibit_rev),
   .servo_on          (servo_on),
   .mains_ok          (mains_ok),
   .drive             (drive),
   .torque_limit_pct  (torque_limit_pct),
   .undervoltage_trip (undervoltage_trip)
);
`default_nettype wire

// File: sss_stop_selector_tb_top.sv
// Purpose: self-checking bench for the stop selector
// Assumes: one ms shortened to 10 clocks
// Notes:   expected values queued, compared when results appear
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module sss_stop_selector_tb_top;
   import sss_pkg::*;
   typedef struct packed {logic [2:0] k; logic [31:0] e;} sss_note_t;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic        hreadyout, hresp, undervoltage_trip, irq, motor_stopped;
   logic [31:0] hrdata, got;
   logic        prohibit_fwd = 1'b0, prohibit_rev = 1'b0, servo_on = 1'b1, mains_ok = 1'b1;
   logic        slow = 1'b0, rd_pend = 1'b0, snap = 1'b0, em, hd, dy;
   logic [9:0]  torque_limit_pct;
   logic [15:0] lfsr = 16'h9C10;
   logic [3:0]  v, cur_sel, c;
   sss_drive_t  drive;
   sss_note_t   notes[$];
   sss_note_t   cur;
   int          bad_count = 0, num_checks = 0;

   sss_stop_selector #(.MS_CYCLES(10)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .prohibit_fwd(prohibit_fwd),
      .prohibit_rev(prohibit_rev), .servo_on(servo_on), .mains_ok(mains_ok), .motor_stopped(motor_stopped),
      .drive(drive), .torque_limit_pct(torque_limit_pct), .undervoltage_trip(undervoltage_trip), .irq(irq));
   sss_motor_model u_motor (.hclk(hclk), .hresetn(hresetn), .drive(drive), .slow(slow),
      .motor_stopped(motor_stopped));

   always #5 hclk = ~hclk;

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next

   task automatic step(input int n);
      repeat (n) @(posedge hclk);
   endtask : step

   // the master waits on ready with no assumed latency; the watchdog ends a hang
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      rd_pend <= ~w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_pend <= 1'b0;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      notes.push_back({3'h0, e});
      bus(1'b0, a, 32'h0);
   endtask : rd

   task automatic pin(input logic [2:0] k, input logic [31:0] e);
      notes.push_back({k, e});
      snap <= 1'b1;
      @(posedge hclk);
      snap <= 1'b0;
      @(posedge hclk);
   endtask : pin

   task automatic do_reset();
      hresetn <= 1'b0;
      step(5);
      hresetn <= 1'b1;
      step(1);
   endtask : do_reset

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : stop_test

   always @(posedge hclk) begin
      if ((rd_pend && hreadyout === 1'b1) || snap) begin
         cur = notes.pop_front();
         case (cur.k)
            3'h0: got = hrdata;
            3'h1: got = {24'h0, drive};
            3'h2: got = {31'h0, undervoltage_trip};
            3'h3: got = {31'h0, irq};
            default: got = {22'h0, torque_limit_pct};
         endcase
         `CHK(got, cur.e)
         if (cur.k == 3'h0) `CHK({31'h0, hresp}, 32'h0)
      end
   end

   // run is about 2560 clocks; the 10000-clock limit allows nearly four times that
   initial begin
      #100000;
      bad_count++;
      stop_test();
   end

   initial begin
      do_reset();
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h0);
      rd(8'h08, 32'h0);
      rd(8'h0C, 32'h1);
      rd(8'h10, 32'h0046_0046);
      rd(8'h14, 32'h0);
      rd(8'h2C, 32'h0);
      wr(8'h00, 32'h3);
      rd(8'h00, 32'h0);
      wr(8'h00, 32'h2);
      rd(8'h00, 32'h2);
      wr(8'h18, 32'h1);
      rd(8'h00, 32'h22);
      cur_sel = 4'h0;
      for (int i = 0; i < 8; i++) begin
         lfsr = lfsr_next(lfsr);
         v = lfsr[3:0];
         if (v <= 4'h9) cur_sel = v;
         wr(8'h04, {28'h0, v});
         rd(8'h04, {28'h0, cur_sel});
      end
      $display("registers done");
      wr(8'h14, 32'h64);
      wr(8'h24, 32'hF);
      wr(8'h28, 32'h1);
      for (int p = 0; p < 3; p++) begin
         wr(8'h00, 32'(p));
         wr(8'h18, 32'h1);
         prohibit_fwd <= (p != 1);
         prohibit_rev <= (p == 1);
         step(6);
         pin(3'h1, {24'h0, p == 1, p != 1, p == 0, p == 1, p == 2, 3'h0});
         pin(3'h4, (p == 2) ? 32'h64 : 32'h1F4);
         prohibit_fwd <= 1'b0;
         prohibit_rev <= 1'b0;
         step(6);
      end
      pin(3'h3, 32'h1);
      rd(8'h20, 32'h1);
      wr(8'h28, 32'h0);
      pin(3'h3, 32'h0);
      wr(8'h24, 32'h1);
      wr(8'h28, 32'h1);
      pin(3'h3, 32'h0);
      $display("prohibit done");
      for (int s = 0; s < 10; s++) begin
         c = 4'(s);
         em = (s >= 8);
         hd = !em && c[2];
         dy = em ? !c[0] : !c[1];
         wr(8'h04, {28'h0, c});
         slow <= c[0];
         servo_on <= 1'b0;
         step(6);
         pin(3'h1, {24'h0, 2'b00, !em && !c[0], !em && c[0], em, 1'b0, !hd, hd});
         step(60);
         pin(3'h1, {24'h0, 2'b00, dy, 2'b00, !dy, !hd, hd});
         servo_on <= 1'b1;
         step(10);
         pin(3'h1, 32'hC0);
         step(4);
      end
      $display("servo off done");
      slow <= 1'b1;
      wr(8'h0C, 32'h0);
      wr(8'h08, 32'h9);
      mains_ok <= 1'b0;
      step(720);
      pin(3'h2, 32'h0);
      pin(3'h1, 32'h0A);
      mains_ok <= 1'b1;
      do_reset();
      step(80);
      mains_ok <= 1'b0;
      step(690);
      pin(3'h2, 32'h0);
      step(30);
      pin(3'h2, 32'h1);
      pin(3'h1, 32'h22);
      mains_ok <= 1'b1;
      $display("mains done");
      stop_test();
   end
endmodule : sss_stop_selector_tb_top
`default_nettype wire
